// [core/rx_align_pkg.sv]
// constants, carriers and phase type for the receive stream framer
// assumes one application clock; the header fields are read in stream byte order
`default_nettype none

package rx_align_pkg;

	// ****************************************************************
	// stream geometry and timing
	// ****************************************************************
	localparam int DWORD_W = 32;
	localparam int BE_W = 4;
	localparam int VALID_DROP_MAX_CYC = 3;

	// ****************************************************************
	// header field positions (header byte 4n sits in the low lane of dword n)
	// ****************************************************************
	localparam int FMT_DATA_BIT = 6;
	localparam int FMT_4DW_BIT = 5;
	localparam int LEN_HI_LSB = 16;
	localparam int LEN_LO_LSB = 24;
	localparam int FBE_LSB = 24;
	localparam int LBE_LSB = 28;
	localparam int ADDR2_BIT = 26;
	localparam logic [1:0] HDR_BE_IDX = 2'h1;
	localparam logic [1:0] HDR3_LAST_IDX = 2'h2;
	localparam logic [1:0] HDR4_LAST_IDX = 2'h3;
	localparam int LEN_W = 11;
	localparam logic [10:0] LEN_MAX = 11'h400;

	// ****************************************************************
	// reset and fill values
	// ****************************************************************
	localparam logic [3:0] BE_NONE = 4'h0;
	localparam logic [3:0] BE_ALL = 4'hf;

	typedef struct packed {
		logic first;
		logic last;
		logic [31:0] dw;
	} recv_tlp_dword_s;

	typedef struct packed {
		logic has_data;
		logic hdr4;
		logic [10:0] len;
	} tlp_info_s;

	typedef enum {PH_HDR, PH_PAY} pack_phase_e;

endpackage

`default_nettype wire

// [core/tlp_hdr_decode.sv]
// header dword 0 decode: payload present, header size, payload dword count
// assumes the dword is in stream byte order, header byte 0 in bits 7:0
`default_nettype none

module tlp_hdr_decode import rx_align_pkg::*; (
	input wire logic [31:0] dw0,
	output tlp_info_s info
);
	logic [9:0] len10;

	always_comb begin
		len10 = {dw0[LEN_HI_LSB + 1:LEN_HI_LSB], dw0[LEN_LO_LSB + 7:LEN_LO_LSB]};
		info.has_data = dw0[FMT_DATA_BIT];
		info.hdr4 = dw0[FMT_4DW_BIT];
		// a zero length field means the largest payload
		info.len = (len10 == 10'h000) ? LEN_MAX : {1'b0, len10};
	end
endmodule

`default_nettype wire

// [core/payload_be_gen.sv]
// byte qualifiers of one payload dword from its index and the header's enables
// assumes len is at least one dword
`default_nettype none

module payload_be_gen import rx_align_pkg::*; (
	input wire logic [10:0] idx,
	input wire logic [10:0] len,
	input wire logic [3:0] fbe,
	input wire logic [3:0] lbe,
	output logic [3:0] be
);
	always_comb begin
		if (idx == 11'h000) begin
			be = fbe;
		end else if (idx == 11'(len - 11'h001)) begin
			be = lbe;
		end else begin
			be = BE_ALL;
		end
	end
endmodule

`default_nettype wire

// [core/rx_stream_framer.sv]
// receive stream framer: packs dword-serial received packets into wide stream words
// assumes the dword source and the application share clk; no pin inputs here
`default_nettype none

module rx_stream_framer import rx_align_pkg::*; #(
	parameter int DATA_W = 128,
	parameter bit MULTI_PKT = 1'b0,
	parameter int HDR_ROOM_W = 8,
	parameter int DATA_ROOM_W = 12,
	localparam int LANES = DATA_W / DWORD_W,
	localparam int SEGS = (DATA_W == 256 && MULTI_PKT) ? 2 : 1,
	localparam int EMPTY_W = (LANES > 2) ? $clog2(LANES / 2) : 1
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire recv_tlp_dword_s tlp_in,
	input wire logic tlp_in_valid,
	output logic tlp_in_ready,
	output logic [DATA_W-1:0] recv_stream_payload,
	output logic recv_stream_word_present,
	input wire logic recv_stream_accept,
	output logic [SEGS-1:0] recv_packet_first_cycle,
	output logic [SEGS-1:0] recv_packet_last_cycle,
	output logic [EMPTY_W-1:0] recv_upper_half_unused,
	output logic [LANES*BE_W-1:0] recv_byte_qualifiers,
	input wire logic [HDR_ROOM_W-1:0] cpl_hdr_free,
	input wire logic [DATA_ROOM_W-1:0] cpl_data_free,
	output logic [HDR_ROOM_W-1:0] completion_header_room,
	output logic [DATA_ROOM_W-1:0] completion_payload_room
);
	localparam int SLOT_W = $clog2(LANES);
	localparam logic [SLOT_W:0] SLOT_END = (SLOT_W + 1)'(LANES);
	localparam logic [SLOT_W:0] SLOT_HALF = (SLOT_W + 1)'(LANES / 2);
	localparam logic [SLOT_W-1:0] SLOT_TOP = SLOT_W'(LANES - 1);
	localparam logic [SLOT_W-1:0] EMPTY_EDGE = SLOT_W'(LANES - 2);
	localparam int DROP_MAX = VALID_DROP_MAX_CYC;

	// ****************************************************************
	// packing state
	// ****************************************************************
	pack_phase_e phase_q;
	logic [SLOT_W:0] slot_q;
	logic [1:0] hdr_idx_q;
	logic [10:0] pay_idx_q;
	tlp_info_s info_q;
	logic [3:0] fbe_q;
	logic [3:0] lbe_q;
	logic lane_q;
	logic hold_q;
	logic in_ready_q;

	logic [DATA_W-1:0] bld_data_q;
	logic [LANES*BE_W-1:0] bld_be_q;
	logic [SEGS-1:0] bld_sop_q;
	logic [SEGS-1:0] bld_eop_q;
	logic [EMPTY_W-1:0] bld_empty_q;
	logic bld_full_q;
	logic bld_full_d;

	logic [DATA_W-1:0] out_data_q;
	logic [LANES*BE_W-1:0] out_be_q;
	logic [SEGS-1:0] out_sop_q;
	logic [SEGS-1:0] out_eop_q;
	logic [EMPTY_W-1:0] out_empty_q;
	logic out_full_q;
	logic out_full_d;
	logic valid_q;
	logic [HDR_ROOM_W-1:0] hdr_room_q;
	logic [DATA_ROOM_W-1:0] data_room_q;

	tlp_info_s dec_info;
	logic [3:0] pay_be;
	logic [3:0] dword_be;
	logic take;
	logic xfer;
	logic load;
	logic hold_close;
	logic is_sop;
	logic hdr_last;
	logic lane_bit;
	logic seg_sel;
	logic hold_open;
	logic word_done;
	logic [SLOT_W-1:0] wslot;
	logic [SLOT_W-1:0] rem;
	logic [SLOT_W:0] nxt;

	tlp_hdr_decode u_dec (
		.dw0(tlp_in.dw),
		.info(dec_info)
	);

	payload_be_gen u_be (
		.idx(pay_idx_q),
		.len(info_q.len),
		.fbe(fbe_q),
		.lbe(lbe_q),
		.be(pay_be)
	);

	// ****************************************************************
	// slot placement
	// ****************************************************************
	assign take = ce && tlp_in_valid && in_ready_q;
	assign xfer = valid_q && recv_stream_accept;
	assign load = ce && bld_full_q && (!out_full_q || xfer);
	assign hold_close = ce && hold_q && !tlp_in_valid;
	assign wslot = slot_q[SLOT_W-1:0];
	assign is_sop = (phase_q == PH_HDR) && (hdr_idx_q == 2'h0);
	assign seg_sel = (SEGS > 1) && wslot[SLOT_W-1];
	assign rem = SLOT_TOP - wslot;

	always_comb begin
		hdr_last = (phase_q == PH_HDR) &&
			(hdr_idx_q == (info_q.hdr4 ? HDR4_LAST_IDX : HDR3_LAST_IDX));
		// requests carry address bit 2 here, completions their lower-address bit 2
		lane_bit = tlp_in.dw[ADDR2_BIT];
		dword_be = (phase_q == PH_PAY) ? pay_be : BE_NONE;
		nxt = slot_q + (SLOT_W + 1)'(1);
		// skip one lane so the first payload dword sits on its qword half
		if (hdr_last && info_q.has_data && !tlp_in.last && (nxt[0] != lane_bit)) begin
			nxt = nxt + (SLOT_W + 1)'(1);
		end
		// a packet ending low in a wide word leaves the high half to the next one
		hold_open = (SEGS > 1) && tlp_in.last && ({1'b0, wslot} < SLOT_HALF);
		word_done = tlp_in.last ? !hold_open : (nxt >= SLOT_END);
	end

	// ****************************************************************
	// packet phase tracking
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (!nrst) begin
			phase_q <= PH_HDR;
			hdr_idx_q <= 2'h0;
			pay_idx_q <= 11'h000;
		end else if (take) begin
			if (tlp_in.last) begin
				// next dword is a new header, no idle cycle needed
				phase_q <= PH_HDR;
				hdr_idx_q <= 2'h0;
			end else if (hdr_last && info_q.has_data) begin
				phase_q <= PH_PAY;
				pay_idx_q <= 11'h000;
			end else if (phase_q == PH_HDR) begin
				hdr_idx_q <= hdr_idx_q + 2'h1;
			end else begin
				pay_idx_q <= pay_idx_q + 11'h001;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			info_q <= '0;
			fbe_q <= BE_NONE;
			lbe_q <= BE_NONE;
			lane_q <= 1'b0;
		end else if (take && phase_q == PH_HDR) begin
			if (hdr_idx_q == 2'h0) begin
				info_q <= dec_info;
			end
			if (hdr_idx_q == HDR_BE_IDX) begin
				fbe_q <= tlp_in.dw[FBE_LSB +: BE_W];
				lbe_q <= tlp_in.dw[LBE_LSB +: BE_W];
			end
			if (hdr_last) begin
				lane_q <= lane_bit;
			end
		end
	end

	// ****************************************************************
	// word builder
	// ****************************************************************
	always_comb begin
		bld_full_d = bld_full_q;
		if (load) begin
			bld_full_d = 1'b0;
		end else if ((take && word_done) || hold_close) begin
			bld_full_d = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			slot_q <= '0;
			hold_q <= 1'b0;
		end else if (take) begin
			// a lane skipped past the word's end stays skipped in the next word
			if (word_done) begin
				slot_q <= tlp_in.last ? '0 : {1'b0, nxt[SLOT_W-1:0]};
			end else begin
				slot_q <= hold_open ? SLOT_HALF : nxt;
			end
			hold_q <= hold_open;
		end else if (hold_close) begin
			slot_q <= '0;
			hold_q <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			bld_full_q <= 1'b0;
			in_ready_q <= 1'b0;
		end else if (ce) begin
			bld_full_q <= bld_full_d;
			// registered ready tracks the builder's fill state; reset loads it low until the first enabled cycle
			in_ready_q <= !bld_full_d;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst || load) begin
			bld_data_q <= '0;
			bld_be_q <= '0;
			bld_sop_q <= '0;
			bld_eop_q <= '0;
			bld_empty_q <= '0;
		end else if (take) begin
			// a later dword takes a higher lane: little-endian packing
			bld_data_q[wslot*DWORD_W +: DWORD_W] <= tlp_in.dw;
			bld_be_q[wslot*BE_W +: BE_W] <= dword_be;
			if (is_sop) begin
				bld_sop_q[seg_sel] <= 1'b1;
			end
			if (tlp_in.last) begin
				bld_eop_q[seg_sel] <= 1'b1;
				// whole unused qwords above the last dword
				bld_empty_q <= EMPTY_W'(rem >> 1);
			end
		end
	end

	// ****************************************************************
	// output stage with backpressure
	// ****************************************************************
	always_comb begin
		out_full_d = out_full_q;
		if (load) begin
			out_full_d = 1'b1;
		end else if (xfer) begin
			out_full_d = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			out_full_q <= 1'b0;
			valid_q <= 1'b0;
		end else if (ce) begin
			out_full_q <= out_full_d;
			// valid follows accept one cycle late, well inside the allowed drop time
			valid_q <= out_full_d && recv_stream_accept;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			out_data_q <= '0;
			out_be_q <= '0;
			out_sop_q <= '0;
			out_eop_q <= '0;
			out_empty_q <= '0;
		end else if (load) begin
			// only a load changes the word, so a stalled word stays put
			out_data_q <= bld_data_q;
			out_be_q <= bld_be_q;
			out_sop_q <= bld_sop_q;
			out_eop_q <= bld_eop_q;
			out_empty_q <= bld_empty_q;
		end
	end

	// room figures are only mirrored; the application must budget its reads
	always_ff @(posedge clk) begin
		if (!nrst) begin
			hdr_room_q <= '0;
			data_room_q <= '0;
		end else if (ce) begin
			hdr_room_q <= cpl_hdr_free;
			data_room_q <= cpl_data_free;
		end
	end

	assign tlp_in_ready = in_ready_q;
	assign recv_stream_payload = out_data_q;
	assign recv_stream_word_present = valid_q;
	assign recv_packet_first_cycle = out_sop_q;
	assign recv_packet_last_cycle = out_eop_q;
	assign recv_upper_half_unused = out_empty_q;
	assign recv_byte_qualifiers = out_be_q;
	assign completion_header_room = hdr_room_q;
	assign completion_payload_room = data_room_q;

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst || !ce);

	sequence seq_stalled;
		out_full_q && !recv_stream_accept;
	endsequence

	sequence seq_resumed;
		out_full_q && recv_stream_accept;
	endsequence

	AST_STALL_DROPS_VALID: assert property (
		(valid_q && !recv_stream_accept) |-> ##[1:DROP_MAX] !valid_q)
		else $error("valid held too long after accept dropped");

	AST_STALL_HOLDS_WORD: assert property (
		(out_full_q && !xfer) |=> ($stable(out_data_q) && $stable(out_be_q)))
		else $error("pending word changed while stalled");

	AST_RESUME_PRESENTS: assert property (
		seq_stalled ##1 seq_resumed |=> valid_q && $stable(out_data_q))
		else $error("stalled word not re-presented after accept returned");

	AST_EMPTY_ONLY_AT_END: assert property (
		(valid_q && out_empty_q != '0) |-> (|out_eop_q))
		else $error("empty flagged outside a last cycle");

	AST_FULL_WORD_EMPTY_LOW: assert property (
		(take && tlp_in.last && wslot >= EMPTY_EDGE) |=> (bld_empty_q == '0))
		else $error("empty set although upper qword holds data");

	AST_PAYLOAD_QWORD_LANE: assert property (
		(take && phase_q == PH_PAY && pay_idx_q == 11'h000) |-> (wslot[0] == lane_q))
		else $error("first payload dword on wrong qword half");

	AST_START_LANE_UNQUALIFIED: assert property (
		(valid_q && out_sop_q[0]) |-> (out_be_q[BE_W-1:0] == BE_NONE))
		else $error("header lane carries byte qualifiers");

	AST_SINGLE_MODE_LOW_START: assert property (
		(take && is_sop && !MULTI_PKT) |-> (wslot == '0))
		else $error("packet started away from lane 0 in single mode");

endmodule

`default_nettype wire

// [verif/rx_app_sink.sv]
// application-side sink model: accepts received stream words and logs them
// assumes a 128-bit stream on the framer's clock; ctrl is {first, last, empty, qualifiers}
`default_nettype none

module rx_app_sink (
	input wire logic clk,
	input wire logic nrst,
	input wire logic stall_on,
	input wire logic present,
	input wire logic [127:0] payload,
	input wire logic [18:0] ctrl,
	output logic accept
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] cnt_q;
	logic [127:0] cap_data [0:15];
	logic [18:0] cap_ctrl [0:15];
	int n_cap;

	// stalls two cycles in four, so a packet is held back in mid-flight
	always_ff @(posedge clk) begin
		if (!nrst) begin
			cnt_q <= 2'h0;
			accept <= 1'b0;
			n_cap <= 0;
		end else begin
			cnt_q <= cnt_q + 2'h1;
			accept <= stall_on ? cnt_q[1] : 1'b1;
			if (present && accept) begin
				cap_data[n_cap[3:0]] <= payload;
				cap_ctrl[n_cap[3:0]] <= ctrl;
				n_cap <= n_cap + 1;
			end
		end
	end
endmodule

`default_nettype wire

// [verif/rx_stream_framer_tb.sv]
// self-checking bench for the receive stream framer at 128 bits, single packet mode
// assumes the sink model logs every transferred word in order
`default_nettype none

module rx_stream_framer_tb;
	import rx_align_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic ce = 1'b1;
	recv_tlp_dword_s tlp_in = '0;
	logic tlp_in_valid = 1'b0;
	logic tlp_in_ready, present, accept, stall_on = 1'b0;
	logic [127:0] pay;
	logic [0:0] first, last, empty;
	logic [15:0] be;
	logic [7:0] hfree = 8'h00, hroom;
	logic [11:0] dfree = 12'h000, droom;
	logic [31:0] pq [$];
	logic [127:0] held;
	logic pend = 1'b0;
	int failures = 0, n_tests = 0, rd = 0, stall_cyc = 0;

	always #5 clk = ~clk;

	rx_stream_framer #(.DATA_W(128)) u_rx_stream_framer (.clk(clk), .nrst(nrst), .ce(ce),
		.tlp_in(tlp_in), .tlp_in_valid(tlp_in_valid), .tlp_in_ready(tlp_in_ready),
		.recv_stream_payload(pay), .recv_stream_word_present(present),
		.recv_stream_accept(accept), .recv_packet_first_cycle(first),
		.recv_packet_last_cycle(last), .recv_upper_half_unused(empty),
		.recv_byte_qualifiers(be), .cpl_hdr_free(hfree), .cpl_data_free(dfree),
		.completion_header_room(hroom), .completion_payload_room(droom));

	rx_app_sink u_rx_app_sink (.clk(clk), .nrst(nrst), .stall_on(stall_on),
		.present(present), .payload(pay), .ctrl({first, last, empty, be}),
		.accept(accept));

	// ****************************************************************
	// stall monitor
	// ****************************************************************
	always @(posedge clk) begin
		if (nrst) begin
			stall_cyc = (present && !accept) ? stall_cyc + 1 : 0;
			if (stall_cyc > 3) begin
				$display("CHECK FAILED valid_drop expected <=3 seen %0d", stall_cyc);
				failures++;
			end
			if (pend && pay !== held) begin
				$display("CHECK FAILED held_word expected %h seen %h", held, pay);
				failures++;
			end
			if (present && !accept) begin
				pend = 1'b1;
				held = pay;
			end else if (present && accept) begin
				pend = 1'b0;
			end
		end
	end

	// ****************************************************************
	// shared tasks
	// ****************************************************************
	task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
		n_tests++;
		if (got !== exp) begin
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
			failures++;
		end
	endtask

	task automatic send_pkt();
		for (int i = 0; i < pq.size(); i++) begin
			@(negedge clk);
			tlp_in = '{first: (i == 0), last: (i == pq.size() - 1), dw: pq[i]};
			tlp_in_valid = 1'b1;
			while (tlp_in_ready !== 1'b1) @(negedge clk);
			@(posedge clk);
		end
	endtask

	task automatic idle();
		@(negedge clk);
		tlp_in_valid = 1'b0;
	endtask

	task automatic exp_word(input logic [127:0] d, input logic [18:0] c);
		int k;
		k = 0;
		while (u_rx_app_sink.n_cap <= rd && k < 100) begin
			@(negedge clk);
			k++;
		end
		if (k >= 100) begin
			$display("CHECK FAILED capture expected word %0d seen none", rd);
			failures++;
		end
		chk("payload", d, u_rx_app_sink.cap_data[rd[3:0]]);
		chk("framing", {109'h0, c}, {109'h0, u_rx_app_sink.cap_ctrl[rd[3:0]]});
		rd++;
	endtask

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic t_back_to_back();
		pq = {32'h02000040, 32'h1e000000, 32'h00000000, 32'h03020100, 32'h07060504};
		send_pkt();
		pq = {32'h01000040, 32'h06000000, 32'h04000000, 32'ha3a2a1a0};
		send_pkt();
		idle();
		exp_word({64'h0, 32'h1e000000, 32'h02000040}, {3'b100, 16'h0000});
		exp_word({64'h0, 32'h07060504, 32'h03020100}, {3'b011, 16'h001e});
		exp_word({32'ha3a2a1a0, 32'h04000000, 32'h06000000, 32'h01000040},
			{3'b110, 16'h6000});
		$display("test back_to_back done");
	endtask

	task automatic t_stall_4dw();
		stall_on = 1'b1;
		pq = {32'h03000060, 32'h3f000000, 32'h0, 32'h04000000,
			32'h13121110, 32'h17161514, 32'h1b1a1918};
		send_pkt();
		idle();
		exp_word({32'h04000000, 32'h0, 32'h3f000000, 32'h03000060}, {3'b100, 16'h0});
		exp_word({32'h1b1a1918, 32'h17161514, 32'h13121110, 32'h0},
			{3'b010, 16'h3ff0});
		stall_on = 1'b0;
		$display("test stall_4dw done");
	endtask

	task automatic t_completion();
		pq = {32'h0100004a, 32'h0f000000, 32'h00000000, 32'hc3c2c1c0};
		send_pkt();
		idle();
		exp_word({32'h0, 32'h0, 32'h0f000000, 32'h0100004a}, {3'b100, 16'h0});
		exp_word({96'h0, 32'hc3c2c1c0}, {3'b011, 16'h000f});
		$display("test completion done");
	endtask

	task automatic t_room();
		@(negedge clk);
		hfree = 8'h5a;
		dfree = 12'h3c7;
		@(negedge clk);
		chk("header_room", 128'h5a, {120'h0, hroom});
		chk("payload_room", 128'h3c7, {116'h0, droom});
		ce = 1'b0;
		hfree = 8'h11;
		@(negedge clk);
		chk("room_frozen", 128'h5a, {120'h0, hroom});
		ce = 1'b1;
		@(negedge clk);
		chk("room_resumed", 128'h11, {120'h0, hroom});
		$display("test room done");
	endtask

	initial begin
		repeat (10) @(negedge clk);
		nrst = 1'b1;
		t_back_to_back();
		t_stall_4dw();
		t_completion();
		t_room();
		test_done();
	end

	// run needs about fifty cycles; 5000 leaves ample margin
	initial begin
		#50000;
		failures++;
		$display("watchdog expired");
		test_done();
	end
endmodule

`default_nettype wire
